/* hdl/sac_pkg.sv */
// Constants for the secondary addressing channel controller
package sac_pkg;
  // Clock
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  // Activation window, 8.192 ms less 6.25 %, longest time rounds down
  localparam int WIN_NS = 8192000;
  localparam int WIN_MIN_NS = WIN_NS - WIN_NS / 16;
  localparam int WIN_CYC = WIN_MIN_NS / CLK_NS;
  // Mode filter, more than 7.680 ms less 6.66 %, least time rounds up
  localparam int MODE_NS = 7680000;
  localparam int MODE_MIN_NS = MODE_NS - (MODE_NS / 10000) * 666;
  localparam int MODE_CYC = (MODE_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Initialization delay after a reset call, 2.048 ms less 6.25 %
  localparam int HOLD_NS = 2048000;
  localparam int HOLD_MIN_NS = HOLD_NS - HOLD_NS / 16;
  localparam int HOLD_CYC = (HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Correlation span between the two receive strobes, 3 us
  localparam int MATCH_NS = 3000;
  localparam logic [6:0] MATCH_CYC = 7'(MATCH_NS / CLK_NS);
  // Timer width
  localparam int TW = 18;
  // Telegram content width (start bit to end bit)
  localparam int TG_W = 14;
  // Burst and error-bit limits
  localparam logic [2:0] MAGIC_N = 3'h4;
  localparam logic [3:0] ERR_LO = 4'h5;
  localparam logic [3:0] ERR_HI = 4'he;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_PHOTO_BIT = 1;
  localparam int STAT_CNT_LSB = 2;
  localparam int STAT_HOLD_BIT = 5;
  // Reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic PHOTO_RST = 1'b1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Channel states
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_ACTIVE = 2'b01,
    SAC_HOLD = 2'b10
  } sac_state_t;
endpackage

/* hdl/sac_ctrl.sv */
// Secondary addressing channel controller with AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// Notes on behaviour
// - While active, secondary input carries commands and status light carries responses.
// - Four correct telegrams within the shortened 8.192 ms window activate the channel.
// - Burst telegrams get no answer and no command processing; syntax checked upstream.
// - In slave mode after init, burst clears outputs, strobes, clears inhibit, activates.
// - Failure after more than 5 and fewer than 14 good bits clears the counter.
// - Failure before the sixth bit leaves the counter unchanged.
// - Secondary telegram matching a main-line telegram clears the counter.
// - Match means strobes at most 3 us apart and equal contents.
// - An IC reset normally deactivates the channel.
// - Locked in photo mode, reset calls keep the channel when inhibit flag is 0.
// - Locked in photo mode, a watchdog reset keeps the channel.
// - Locked photo reset call clears outputs with strobes, then blocks input 2.048 ms less 6.25 %.
// - Locked in photo mode, the receiver stays in synchronous receive mode.
// - Input mode changes only while unlocked; locked mode holds until the channel drops back to idle.
// - Long high selects logic-level mode; equally long low returns to photo mode.
// - Input level at end of initialization picks the starting input mode.
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int WIN_CYC_P = sac_pkg::WIN_CYC,
  parameter int MODE_CYC_P = sac_pkg::MODE_CYC,
  parameter int HOLD_CYC_P = sac_pkg::HOLD_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Secondary input pin
  input wire logic secondary_cmd_input,
  // Device status
  input wire logic slave_mode,
  input wire logic init_done,
  input wire logic exch_inhibit,
  // Receiver results, secondary channel
  input wire logic sec_rx_ok,
  input wire logic [sac_pkg::TG_W-1:0] sec_rx_data,
  input wire logic sec_rx_err,
  input wire logic [3:0] sec_rx_bits,
  // Receiver results, main line
  input wire logic main_rx_ok,
  input wire logic [sac_pkg::TG_W-1:0] main_rx_data,
  // Reset causes
  input wire logic reset_call,
  input wire logic wdog_reset,
  input wire logic ic_reset,
  // Response and normal light sources
  input wire logic resp_tx,
  input wire logic led_normal,
  // Channel outputs
  output logic channel_active,
  output logic photo_current_input_mode,
  output logic status_light_output,
  output logic sync_rx_mode,
  output logic rx_block,
  output logic sec_cmd_valid,
  output logic io_clear,
  output logic data_strobe,
  output logic param_strobe,
  output logic exch_inhibit_clr
);
  import sac_pkg::*;

  // Register and state declarations
  logic in_s1_r, in_s2_r;
  sac_state_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [TW-1:0] win_r, win_nxt, hi_r, hi_nxt, lo_r, lo_nxt, hold_r, hold_nxt;
  logic photo_r, photo_nxt, init_q_r;
  logic [6:0] sec_age_r, sec_age_nxt, main_age_r, main_age_nxt;
  logic [TG_W-1:0] sec_d_r, sec_d_nxt, main_d_r, main_d_nxt;
  logic clr_r, clr_nxt, act_pls_r, act_pls_nxt, fwd_r, fwd_nxt;
  logic light_r, light_nxt;
  logic [2:0] chan_o_r, chan_o_nxt;
  logic en_r, en_nxt;
  logic aw_r, aw_nxt, bv_r, bv_nxt, ar_r, ar_nxt, rv_r, rv_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic match, locked_photo, burst_ok, err_clr;

  // Saturating age counter increment
  function automatic logic [6:0] age_inc(input logic [6:0] a);
    age_inc = (a == 7'h7f) ? a : a + 7'h01;
  endfunction

  // Pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_r <= 1'b0;
      in_s2_r <= 1'b0;
    end else begin
      in_s1_r <= secondary_cmd_input;
      in_s2_r <= in_s1_r;
    end
  end

  // Correlation of the two receivers
  always_comb begin
    sec_age_nxt = sec_rx_ok ? 7'h00 : age_inc(sec_age_r);
    main_age_nxt = main_rx_ok ? 7'h00 : age_inc(main_age_r);
    sec_d_nxt = sec_rx_ok ? sec_rx_data : sec_d_r;
    main_d_nxt = main_rx_ok ? main_rx_data : main_d_r;
    match = 1'b0;
    if (sec_rx_ok && main_rx_ok && sec_rx_data == main_rx_data)
      match = 1'b1;
    else if (sec_rx_ok && main_age_r < MATCH_CYC && sec_rx_data == main_d_r)
      match = 1'b1;
    else if (main_rx_ok && sec_age_r < MATCH_CYC && main_rx_data == sec_d_r)
      match = 1'b1;
  end

  // Channel state, burst counter, timers and input mode
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    hold_nxt = hold_r;
    photo_nxt = photo_r;
    hi_nxt = in_s2_r ? hi_r + ((hi_r == '1) ? TW'(0) : TW'(1)) : '0;
    lo_nxt = in_s2_r ? '0 : lo_r + ((lo_r == '1) ? TW'(0) : TW'(1));
    clr_nxt = 1'b0;
    act_pls_nxt = 1'b0;
    fwd_nxt = 1'b0;
    locked_photo = (st_r != SAC_IDLE) && photo_r;
    burst_ok = en_r && slave_mode && init_done && st_r == SAC_IDLE;
    err_clr = sec_rx_err && sec_rx_bits > ERR_LO && sec_rx_bits < ERR_HI;
    // Burst counting and its guards
    if (cnt_r != 3'h0)
      win_nxt = win_r + TW'(1);
    if (!burst_ok || match || err_clr) begin
      cnt_nxt = 3'h0;
    end else if (cnt_r != 3'h0 && win_r >= TW'(WIN_CYC_P)) begin
      cnt_nxt = 3'h0;
    end else if (sec_rx_ok) begin
      if (cnt_r == MAGIC_N - 3'h1) begin
        st_nxt = SAC_ACTIVE;
        cnt_nxt = 3'h0;
        clr_nxt = 1'b1;
        act_pls_nxt = 1'b1;
      end else begin
        if (cnt_r == 3'h0)
          win_nxt = '0;
        cnt_nxt = cnt_r + 3'h1;
      end
    end
    // Commands pass on only from an active channel
    if (st_r == SAC_ACTIVE && sec_rx_ok)
      fwd_nxt = 1'b1;
    // Hold after a reset call
    if (st_r == SAC_HOLD) begin
      hold_nxt = hold_r + TW'(1);
      if (hold_r >= TW'(HOLD_CYC_P) - TW'(1))
        st_nxt = SAC_ACTIVE;
    end
    // Reset causes
    if (reset_call) begin
      if (locked_photo && !exch_inhibit) begin
        st_nxt = SAC_HOLD;
        hold_nxt = '0;
        clr_nxt = 1'b1;
      end else begin
        st_nxt = SAC_IDLE;
      end
      cnt_nxt = 3'h0;
    end else if (wdog_reset) begin
      if (!locked_photo)
        st_nxt = SAC_IDLE;
      else
        st_nxt = st_r;
      cnt_nxt = 3'h0;
    end else if (ic_reset) begin
      st_nxt = SAC_IDLE;
      cnt_nxt = 3'h0;
    end
    // Input mode follows the filtered level only while unlocked
    if (st_r == SAC_IDLE) begin
      if (init_done && !init_q_r)
        photo_nxt = !in_s2_r;
      else if (hi_r > TW'(MODE_CYC_P))
        photo_nxt = 1'b0;
      else if (lo_r > TW'(MODE_CYC_P))
        photo_nxt = 1'b1;
    end
    // Light shows responses while the channel is active
    light_nxt = (st_r != SAC_IDLE) ? resp_tx : led_normal;
    chan_o_nxt = {st_nxt != SAC_IDLE, (st_nxt != SAC_IDLE) && photo_nxt, st_nxt == SAC_HOLD};
  end

  // Channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= SAC_IDLE;
      cnt_r <= 3'h0;
      win_r <= '0;
      hold_r <= '0;
      hi_r <= '0;
      lo_r <= '0;
      photo_r <= PHOTO_RST;
      init_q_r <= 1'b0;
      sec_age_r <= 7'h7f;
      main_age_r <= 7'h7f;
      sec_d_r <= '0;
      main_d_r <= '0;
      clr_r <= 1'b0;
      act_pls_r <= 1'b0;
      fwd_r <= 1'b0;
      light_r <= 1'b1;
      chan_o_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      hold_r <= hold_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      photo_r <= photo_nxt;
      init_q_r <= init_done;
      sec_age_r <= sec_age_nxt;
      main_age_r <= main_age_nxt;
      sec_d_r <= sec_d_nxt;
      main_d_r <= main_d_nxt;
      clr_r <= clr_nxt;
      act_pls_r <= act_pls_nxt;
      fwd_r <= fwd_nxt;
      light_r <= light_nxt;
      chan_o_r <= chan_o_nxt;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  always_comb begin
    en_nxt = en_r;
    aw_nxt = 1'b0;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    ar_nxt = 1'b0;
    rv_nxt = rv_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (bv_r && s_axi_bready)
      bv_nxt = 1'b0;
    if (!bv_r && !aw_r && s_axi_awvalid && s_axi_wvalid) begin
      aw_nxt = 1'b1;
      bv_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (s_axi_awaddr[7:2] == CTRL_OFS[7:2]) begin
        if (s_axi_wstrb[0])
          en_nxt = s_axi_wdata[CTRL_EN_BIT];
      end else if (s_axi_awaddr[7:2] != STAT_OFS[7:2]) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (rv_r && s_axi_rready)
      rv_nxt = 1'b0;
    if (!rv_r && !ar_r && s_axi_arvalid) begin
      ar_nxt = 1'b1;
      rv_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr[7:2] == CTRL_OFS[7:2]) begin
        rdata_nxt[CTRL_EN_BIT] = en_r;
      end else if (s_axi_araddr[7:2] == STAT_OFS[7:2]) begin
        rdata_nxt[STAT_ACT_BIT] = st_r != SAC_IDLE;
        rdata_nxt[STAT_PHOTO_BIT] = photo_r;
        rdata_nxt[STAT_CNT_LSB +: 3] = cnt_r;
        rdata_nxt[STAT_HOLD_BIT] = st_r == SAC_HOLD;
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= CTRL_EN_RST;
      aw_r <= 1'b0;
      bv_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      ar_r <= 1'b0;
      rv_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      en_r <= en_nxt;
      aw_r <= aw_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      ar_r <= ar_nxt;
      rv_r <= rv_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = aw_r;
  assign s_axi_wready = aw_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ar_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign channel_active = chan_o_r[2];
  assign photo_current_input_mode = photo_r;
  assign status_light_output = light_r;
  assign sync_rx_mode = chan_o_r[1];
  assign rx_block = chan_o_r[0];
  assign sec_cmd_valid = fwd_r;
  assign io_clear = clr_r;
  assign data_strobe = clr_r;
  assign param_strobe = clr_r;
  assign exch_inhibit_clr = act_pls_r;
endmodule // sac_ctrl

/* testbench/sac_ctrl_asserts.sv */
// Concurrent checks on the channel controller ports
`timescale 1ns/10ps
module sac_ctrl_chk (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Causes
  input logic sec_rx_ok,
  input logic reset_call,
  input logic wdog_reset,
  input logic ic_reset,
  input logic exch_inhibit,
  input logic resp_tx,
  // Channel outputs
  input logic channel_active,
  input logic photo_current_input_mode,
  input logic status_light_output,
  input logic sync_rx_mode,
  input logic rx_block,
  input logic sec_cmd_valid,
  input logic io_clear,
  input logic data_strobe,
  input logic param_strobe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Locked in photo mode and not holding off
  wire lp = channel_active && photo_current_input_mode && !rx_block;
  // Channel behaviour
  property p_fwd; sec_cmd_valid |-> $past(sec_rx_ok) && channel_active && !$past(rx_block); endproperty
  a_fwd: assert property (p_fwd) else $error("command forwarded off a live channel");
  property p_led; channel_active |=> status_light_output == $past(resp_tx); endproperty
  a_led: assert property (p_led) else $error("status light not carrying response");
  property p_act; $rose(channel_active) && !$past(rx_block) |-> io_clear && data_strobe && param_strobe; endproperty
  a_act: assert property (p_act) else $error("activation without output clear");
  property p_syn; channel_active && photo_current_input_mode |-> sync_rx_mode; endproperty
  a_syn: assert property (p_syn) else $error("receiver left synchronous mode");
  property p_lck; channel_active |=> $stable(photo_current_input_mode); endproperty
  a_lck: assert property (p_lck) else $error("input mode changed while locked");
  property p_hld; lp && reset_call && !exch_inhibit |=> rx_block && io_clear; endproperty
  a_hld: assert property (p_hld) else $error("reset call did not hold off");
  property p_wdg; lp && wdog_reset |=> channel_active; endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog reset dropped channel");
  property p_ic; ic_reset |=> !channel_active; endproperty
  a_ic: assert property (p_ic) else $error("chip reset kept channel");
  // Main scenarios
  c_act: cover property ($rose(channel_active));
  c_hld: cover property ($rose(rx_block));
  c_mod: cover property ($fell(photo_current_input_mode));
endmodule // sac_ctrl_chk
bind sac_ctrl sac_ctrl_chk u_chk (.*);

/* testbench/sac_prog.sv */
// Handheld programmer model driving the secondary pin and receiver results
`timescale 1ns/10ps
module sac_prog
  import sac_pkg::*;
(
  // Clock
  input logic aclk,
  // Secondary pin and decoded results
  output logic secondary_cmd_input,
  output logic sec_rx_ok,
  output logic [sac_pkg::TG_W-1:0] sec_rx_data,
  output logic sec_rx_err,
  output logic [3:0] sec_rx_bits
);
  // Quiet lines at start
  initial begin
    {secondary_cmd_input, sec_rx_ok, sec_rx_err, sec_rx_data, sec_rx_bits} = '0;
  end
  // One telegram: good when e is 0, else failed after d[3:0] good bits; stale values inverted after
  task automatic tg(input logic e, input logic [TG_W-1:0] d);
    @(posedge aclk);
    {sec_rx_ok, sec_rx_err} <= {!e, e};
    sec_rx_data <= d;
    sec_rx_bits <= d[3:0];
    @(posedge aclk);
    {sec_rx_ok, sec_rx_err} <= 2'h0;
    sec_rx_data <= ~d;
    sec_rx_bits <= ~d[3:0];
  endtask
  // Steady pin level
  task automatic lvl(input logic v);
    @(posedge aclk);
    secondary_cmd_input <= v;
  endtask
endmodule // sac_prog

/* testbench/sac_ctrl_tb.sv */
// Self-checking bench for the secondary addressing channel controller
`timescale 1ns/10ps
module sac_ctrl_tb;
  import sac_pkg::*;
  // Shortened counts
  localparam int WP = 400;
  localparam int MP = 100;
  localparam int HP = 50;
  // Nets of the design and the programmer model
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, secondary_cmd_input, slave_mode, init_done;
  logic exch_inhibit, sec_rx_ok, sec_rx_err, main_rx_ok, reset_call, wdog_reset, ic_reset, resp_tx, led_normal;
  logic channel_active, photo_current_input_mode, status_light_output, sync_rx_mode, rx_block, sec_cmd_valid;
  logic io_clear, data_strobe, param_strobe, exch_inhibit_clr, v;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, sec_rx_bits, rc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [TG_W-1:0] sec_rx_data, main_rx_data;
  int err_count, tests_run;
  assign {main_rx_ok, reset_call, wdog_reset, ic_reset} = rc;
  sac_ctrl #(.WIN_CYC_P(WP), .MODE_CYC_P(MP), .HOLD_CYC_P(HP)) uut (.*);
  sac_prog prog (.*);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Let n edges pass, then settle to the falling edge
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // AXI4-Lite write, response kept in rr
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // AXI4-Lite read into rd and rr
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // Burst counter from the status word
  task automatic cnt(input logic [2:0] e);
    axr(STAT_OFS);
    chk("count", 32'(e), 32'(rd[STAT_CNT_LSB+:3]));
  endtask
  // Pulse of main-line strobe or reset causes, with main-line content
  task automatic pu(input logic [3:0] c, input logic [TG_W-1:0] d);
    @(posedge aclk);
    {rc, main_rx_data} <= {c, d};
    @(posedge aclk);
    {rc, main_rx_data} <= {4'h0, ~d};
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #160000;
    err_count++;
    summarize;
  end
  // Test sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, init_done} = '0;
    {exch_inhibit, rc, s_axi_awaddr, s_axi_araddr, s_axi_wdata, main_rx_data} = '0;
    {slave_mode, led_normal, resp_tx, s_axi_wstrb} = 7'h7f;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    prog.lvl(1'b1);
    w(4);
    @(posedge aclk) init_done <= 1'b1;
    w(2);
    chk("start mode", 32'h0, 32'(photo_current_input_mode));
    // Mode filter both ways
    for (int i = 0; i < 3; i++) begin
      v = i[0];
      prog.lvl(v);
      w(MP - 10);
      chk("mode kept", 32'(v), 32'(photo_current_input_mode));
      w(20);
      chk("mode moved", 32'(!v), 32'(photo_current_input_mode));
    end
    // Control register, unmapped place, detection off
    axr(CTRL_OFS);
    chk("ctrl", 32'(CTRL_EN_RST), 32'(rd[CTRL_EN_BIT]));
    axr(8'h40);
    chk("unmapped", {30'h0, RESP_SLVERR}, {rd[29:0], rr});
    axw(8'h40, 32'h1);
    chk("wr unmapped", 32'(RESP_SLVERR), 32'(rr));
    axw(CTRL_OFS, 32'h0);
    chk("wr resp", 32'(RESP_OKAY), 32'(rr));
    repeat (3) prog.tg(1'b0, 14'h0111);
    cnt(3'h0);
    axw(CTRL_OFS, 32'h1);
    // Failures before and after the sixth bit
    prog.tg(1'b0, 14'h0222);
    prog.tg(1'b0, 14'h0223);
    prog.tg(1'b1, 14'h0005);
    cnt(3'h2);
    prog.tg(1'b1, 14'h0006);
    cnt(3'h0);
    prog.tg(1'b0, 14'h0224);
    prog.tg(1'b1, 14'h000e);
    cnt(3'h1);
    prog.tg(1'b1, 14'h000d);
    cnt(3'h0);
    // Correlation with the main line, then window expiry
    prog.tg(1'b0, 14'h0301);
    pu(4'h8, 14'h0302);
    prog.tg(1'b0, 14'h0302);
    cnt(3'h0);
    pu(4'h8, 14'h0303);
    prog.tg(1'b0, 14'h0304);
    pu(4'h8, 14'h0305);
    w(int'(MATCH_CYC) + 5);
    prog.tg(1'b0, 14'h0305);
    cnt(3'h2);
    w(WP + 10);
    cnt(3'h0);
    // Activation burst
    for (int i = 0; i < 3; i++)
      prog.tg(1'b0, 14'(i));
    cnt(3'h3);
    prog.tg(1'b0, 14'h0aaa);
    w(0);
    chk("act", 32'h1f, 32'({channel_active, io_clear, data_strobe, param_strobe, exch_inhibit_clr}));
    chk("burst fwd", 32'h0, 32'(sec_cmd_valid));
    // Live channel traffic
    prog.tg(1'b0, 14'h0bbb);
    w(0);
    chk("fwd", 32'h1, 32'(sec_cmd_valid));
    @(posedge aclk) resp_tx <= 1'b0;
    w(1);
    chk("light", 32'h0, 32'(status_light_output));
    prog.lvl(1'b1);
    w(MP + 10);
    chk("lock", 32'h3, 32'({photo_current_input_mode, sync_rx_mode}));
    pu(4'h2, 14'h0000);
    w(1);
    chk("wdog", 32'h1, 32'(channel_active));
    pu(4'h4, 14'h0000);
    w(0);
    chk("hold", 32'h3, 32'({rx_block, io_clear}));
    prog.tg(1'b0, 14'h0ccc);
    w(0);
    chk("blocked", 32'h0, 32'(sec_cmd_valid));
    axr(STAT_OFS);
    chk("status", 32'h23, rd);
    w(HP - 12);
    chk("hold on", 32'h1, 32'(rx_block));
    w(20);
    chk("kept", 32'h1, 32'({rx_block, channel_active}));
    pu(4'h1, 14'h0000);
    w(0);
    chk("chip reset", 32'h0, 32'(channel_active));
    w(1);
    chk("unlocked", 32'h0, 32'(photo_current_input_mode));
    // Relock in photo mode, then a reset call with the inhibit flag set drops the channel
    prog.lvl(1'b0);
    w(MP + 10);
    for (int i = 0; i < 4; i++)
      prog.tg(1'b0, 14'h0010 + 14'(i));
    w(0);
    chk("relock", 32'h3, 32'({channel_active, photo_current_input_mode}));
    @(posedge aclk) exch_inhibit <= 1'b1;
    pu(4'h4, 14'h0000);
    w(0);
    chk("inhibit drop", 32'h0, 32'({channel_active, rx_block}));
    summarize;
  end
endmodule // sac_ctrl_tb
